/* File: hdl/tsd_delay_lines.sv */
// two-instance tapped shift delay line
`timescale 1ns/1ps
`default_nettype none

module tsd_delay_lines (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic clock_en_i,
    input wire tsd_pkg::tsd_in_s [tsd_pkg::TSD_LINES-1:0] line_in_i,
    input wire tsd_pkg::tsd_cfg_s [tsd_pkg::TSD_LINES-1:0] line_cfg_i,
    output tsd_pkg::tsd_out_s [tsd_pkg::TSD_LINES-1:0] line_out_o
);
    import tsd_pkg::*;

    // ----------------------------------------------------------------
    // configuration latch
    // ----------------------------------------------------------------
    // taps are captured only while the line is held in reset, so the
    // delay is fixed by configuration and never moves at run time
    tsd_cfg_s [TSD_LINES-1:0] cfg_reg;
    tsd_cfg_s [TSD_LINES-1:0] cfg_next;

    // ----------------------------------------------------------------
    // chains and taps
    // ----------------------------------------------------------------
    // the matrix-selected shifting clock is treated as a synchronous
    // enable: one stage moves per rising edge of it
    logic [TSD_LINES-1:0] shift_clk_q_reg;
    logic [TSD_LINES-1:0] shift_edge;
    logic [TSD_LINES-1:0] line_rst;
    logic [TSD_STAGES-1:0] chain_reg [TSD_LINES];
    logic [TSD_STAGES-1:0] chain_next [TSD_LINES];

    genvar g;
    generate
        for (g = 0; g < TSD_LINES; g++) begin : gen_line
            assign line_rst[g] = line_in_i[g].reset;
            assign shift_edge[g] = line_in_i[g].shift_clk & ~shift_clk_q_reg[g];
            assign chain_next[g] = {chain_reg[g][TSD_STAGES-2:0], line_in_i[g].data};
            assign cfg_next[g] = line_rst[g] ? line_cfg_i[g] : cfg_reg[g];

            // independent tap multiplexers
            assign line_out_o[g].delayed_output_a = chain_reg[g][cfg_reg[g].tap_a];
            assign line_out_o[g].delayed_output_b = chain_reg[g][cfg_reg[g].tap_b];

            always_ff @(posedge clock_i or posedge reset_i) begin
                if (reset_i) begin
                    chain_reg[g] <= TSD_CHAIN_RST;
                    shift_clk_q_reg[g] <= 1'b0;
                    cfg_reg[g] <= '{tap_a: TSD_SEL_RST, tap_b: TSD_SEL_RST};
                end else if (clock_en_i) begin
                    shift_clk_q_reg[g] <= line_in_i[g].shift_clk;
                    cfg_reg[g] <= cfg_next[g];
                    if (line_rst[g]) begin
                        chain_reg[g] <= TSD_CHAIN_RST;
                    end else if (shift_edge[g]) begin
                        chain_reg[g] <= chain_next[g];
                    end
                end
            end

            // --------------------------------------------------------
            // checks
            // --------------------------------------------------------
            property p_shift_one_stage;
                @(posedge clock_i) disable iff (reset_i)
                (clock_en_i && shift_edge[g] && !line_rst[g])
                |=> chain_reg[g] == $past(chain_next[g]);
            endproperty
            a_shift_one_stage: assert property (p_shift_one_stage)
                else $error("chain did not advance by one stage");

            property p_first_stage;
                @(posedge clock_i) disable iff (reset_i)
                (clock_en_i && shift_edge[g] && !line_rst[g])
                |=> chain_reg[g][0] == $past(line_in_i[g].data);
            endproperty
            a_first_stage: assert property (p_first_stage)
                else $error("first stage missed the input");

            property p_hold;
                @(posedge clock_i) disable iff (reset_i)
                (!clock_en_i || (!shift_edge[g] && !line_rst[g]))
                |=> $stable(chain_reg[g]);
            endproperty
            a_hold: assert property (p_hold)
                else $error("chain moved without a shifting edge");

            property p_clear;
                @(posedge clock_i) disable iff (reset_i)
                (clock_en_i && line_rst[g]) |=> chain_reg[g] == TSD_CHAIN_RST;
            endproperty
            a_clear: assert property (p_clear)
                else $error("line reset did not clear the chain");

            property p_cleared_out;
                @(posedge clock_i) disable iff (reset_i)
                (clock_en_i && line_rst[g])
                |=> !line_out_o[g].delayed_output_a && !line_out_o[g].delayed_output_b;
            endproperty
            a_cleared_out: assert property (p_cleared_out)
                else $error("outputs not low after line reset");

            // --------------------------------------------------------
            // tap checks
            // --------------------------------------------------------
            // a deeper tap shows, after a shift, what the stage before it held
            property p_tap_a;
                @(posedge clock_i) disable iff (reset_i)
                (clock_en_i && shift_edge[g] && !line_rst[g] && (|cfg_reg[g].tap_a))
                |=> line_out_o[g].delayed_output_a
                    == $past(chain_reg[g][cfg_reg[g].tap_a - 1'b1]);
            endproperty
            a_tap_a: assert property (p_tap_a)
                else $error("output a shows the wrong stage");

            property p_tap_b;
                @(posedge clock_i) disable iff (reset_i)
                (clock_en_i && shift_edge[g] && !line_rst[g] && (|cfg_reg[g].tap_b))
                |=> line_out_o[g].delayed_output_b
                    == $past(chain_reg[g][cfg_reg[g].tap_b - 1'b1]);
            endproperty
            a_tap_b: assert property (p_tap_b)
                else $error("output b shows the wrong stage");

            property p_tap_a_first;
                @(posedge clock_i) disable iff (reset_i)
                (clock_en_i && shift_edge[g] && !line_rst[g] && !(|cfg_reg[g].tap_a))
                |=> line_out_o[g].delayed_output_a == $past(line_in_i[g].data);
            endproperty
            a_tap_a_first: assert property (p_tap_a_first)
                else $error("output a at one stage missed the input");

            property p_tap_b_first;
                @(posedge clock_i) disable iff (reset_i)
                (clock_en_i && shift_edge[g] && !line_rst[g] && !(|cfg_reg[g].tap_b))
                |=> line_out_o[g].delayed_output_b == $past(line_in_i[g].data);
            endproperty
            a_tap_b_first: assert property (p_tap_b_first)
                else $error("output b at one stage missed the input");

            property p_cfg_fixed;
                @(posedge clock_i) disable iff (reset_i)
                !line_rst[g] |=> $stable(cfg_reg[g]);
            endproperty
            a_cfg_fixed: assert property (p_cfg_fixed)
                else $error("tap selection changed while running");

            // --------------------------------------------------------
            // reset, freeze and shift checks
            // --------------------------------------------------------
            // taps fall back to one stage until the next line reset
            property p_released_clear;
                @(posedge clock_i) disable iff (reset_i)
                $past(reset_i)
                |-> chain_reg[g] == TSD_CHAIN_RST && cfg_reg[g] == {TSD_SEL_RST, TSD_SEL_RST};
            endproperty
            a_released_clear: assert property (p_released_clear)
                else $error("line not clear after system reset");

            property p_frozen;
                @(posedge clock_i) disable iff (reset_i)
                !clock_en_i |=> $stable(shift_clk_q_reg[g]) && $stable(cfg_reg[g]);
            endproperty
            a_frozen: assert property (p_frozen)
                else $error("state moved while the clock enable was low");

            property p_edge_tracks;
                @(posedge clock_i) disable iff (reset_i)
                clock_en_i |=> shift_clk_q_reg[g] == $past(line_in_i[g].shift_clk);
            endproperty
            a_edge_tracks: assert property (p_edge_tracks)
                else $error("shifting clock history lost");

            // the shifting clock needs a low sample between two edges
            property p_single_shift;
                @(posedge clock_i) disable iff (reset_i)
                (clock_en_i && shift_edge[g]) |=> !shift_edge[g];
            endproperty
            a_single_shift: assert property (p_single_shift)
                else $error("two shifts from one shifting clock pulse");

            property p_cfg_load;
                @(posedge clock_i) disable iff (reset_i)
                (clock_en_i && line_rst[g]) |=> cfg_reg[g] == $past(line_cfg_i[g]);
            endproperty
            a_cfg_load: assert property (p_cfg_load)
                else $error("tap selection not loaded during line reset");

            property p_last_stage;
                @(posedge clock_i) disable iff (reset_i)
                (clock_en_i && shift_edge[g] && !line_rst[g])
                |=> chain_reg[g][TSD_STAGES-1] == $past(chain_reg[g][TSD_STAGES-2]);
            endproperty
            a_last_stage: assert property (p_last_stage)
                else $error("last stage did not take the stage before it");

            property p_out_stable;
                @(posedge clock_i) disable iff (reset_i)
                (!clock_en_i || (!shift_edge[g] && !line_rst[g]))
                |=> $stable(line_out_o[g]);
            endproperty
            a_out_stable: assert property (p_out_stable)
                else $error("tap output moved without a shift");
        end
    endgenerate
endmodule

`default_nettype wire

/* File: common/tsd_pkg.sv */
// package for the tapped shift delay line
package tsd_pkg;
    localparam int unsigned TSD_STAGES = 16;
    localparam int unsigned TSD_SEL_W = 4;
    localparam int unsigned TSD_LINES = 2;
    localparam logic [TSD_STAGES-1:0] TSD_CHAIN_RST = 16'h0000;
    localparam logic [TSD_SEL_W-1:0] TSD_SEL_RST = 4'h0;

    // per-line tap configuration: select value n picks stage n+1
    typedef struct packed {
        logic [TSD_SEL_W-1:0] tap_a;
        logic [TSD_SEL_W-1:0] tap_b;
    } tsd_cfg_s;

    // per-line matrix inputs
    typedef struct packed {
        logic data;
        logic shift_clk;
        logic reset;
    } tsd_in_s;

    // per-line tap outputs
    typedef struct packed {
        logic delayed_output_a;
        logic delayed_output_b;
    } tsd_out_s;
endpackage

/* File: bench/tsd_matrix_model.sv */
// routing matrix model that feeds both delay lines
`timescale 1ns/1ps
`default_nettype none
module tsd_matrix_model (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [3:0] rnd_i,
    input wire logic [1:0] lrst_i,
    input wire logic osc_sel_i,
    output var tsd_pkg::tsd_in_s [1:0] line_in_o
);
    import tsd_pkg::*;
    logic [2:0] osc_reg;
    logic [1:0] hold_reg;
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            osc_reg <= 3'h0;
            hold_reg <= 2'h0;
            line_in_o <= '0;
        end else begin
            osc_reg <= osc_reg + 3'h1;
            hold_reg <= lrst_i;
            for (int l = 0; l < 2; l++) begin
                // low one cycle past reset so a fresh edge is always seen
                line_in_o[l].shift_clk <= !(lrst_i[l] | hold_reg[l])
                    && (osc_sel_i ? osc_reg[l+1] : rnd_i[2*l]);
                line_in_o[l].data <= rnd_i[2*l+1];
                line_in_o[l].reset <= lrst_i[l];
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/tsd_delay_lines_bench.sv */
// self-checking bench for the tapped shift delay line
`timescale 1ns/1ps
`default_nettype none
module tsd_delay_lines_bench;
    import tsd_pkg::*;
    logic clock_i = 1'b0, reset_i = 1'b1, clock_en_i = 1'b0, osc_sel = 1'b0;
    logic [3:0] rnd = 4'h0;
    logic [1:0] lrst = 2'h0;
    logic [7:0] r;
    tsd_cfg_s [1:0] cfg = '0;
    tsd_in_s [1:0] lin;
    tsd_out_s [1:0] lout;
    logic [15:0] ch [2];
    tsd_cfg_s tp [2];
    logic pv [2];
    int n_errors = 0, checked = 0;
    tsd_delay_lines u_dut (.clock_i(clock_i), .reset_i(reset_i), .clock_en_i(clock_en_i),
        .line_in_i(lin), .line_cfg_i(cfg), .line_out_o(lout));
    tsd_matrix_model u_mx (.clock_i(clock_i), .reset_i(reset_i), .rnd_i(rnd),
        .lrst_i(lrst), .osc_sel_i(osc_sel), .line_in_o(lin));
    initial forever #5 clock_i = ~clock_i;
    function automatic tsd_out_s expect_out(logic [15:0] c, tsd_cfg_s t);
        return {c[t.tap_a], c[t.tap_b]};
    endfunction
    // reference chains see the same sampled inputs as the design
    always @(posedge clock_i or posedge reset_i) begin
        for (int l = 0; l < 2; l++) begin
            if (reset_i) begin
                ch[l] = '0;
                tp[l] = '0;
                pv[l] = 1'b0;
            end else if (clock_en_i) begin
                if (lin[l].reset) begin
                    ch[l] = '0;
                    tp[l] = cfg[l];
                end else if (lin[l].shift_clk && !pv[l]) begin
                    ch[l] = {ch[l][14:0], lin[l].data};
                end
                pv[l] = lin[l].shift_clk;
            end
        end
    end
    always @(negedge clock_i) begin
        for (int l = 0; l < 2; l++) begin
            checked++;
            if (lout[l] !== expect_out(ch[l], tp[l])) begin
                n_errors++;
                $display("ERROR %0t got %h exp %h", $time, lout[l], expect_out(ch[l], tp[l]));
            end
        end
    end
    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h1e4a129a));
        repeat (12) @(posedge clock_i);
        reset_i <= 1'b0;
        for (int t = 0; t < 40; t++) begin
            // every tap value on both outputs first, then random taps
            cfg <= t < 16 ? {2{t[3:0], 4'hf - t[3:0]}} : 16'($urandom);
            clock_en_i <= 1'b1;
            lrst <= 2'h3;
            osc_sel <= t[0];
            if (t == 20) reset_i <= 1'b1;
            @(posedge clock_i);
            reset_i <= 1'b0;
            for (int k = 0; k < 40; k++) begin
                r = 8'($urandom);
                rnd <= r[3:0];
                lrst <= {1'b0, r[7:3] == 5'h0};
                clock_en_i <= r[6:4] != 3'h0;
                @(posedge clock_i);
            end
        end
        conclude();
    end
endmodule
`default_nettype wire
